// [design/lms_pkg.sv]
// shared constants and types for the adaptive fir datapath
package lms_pkg;

  localparam int unsigned W_WORDS = 256;
  localparam int unsigned D_WORDS = 256;
  localparam int unsigned S_WORDS = 32;
  localparam int unsigned TOTAL_WORDS = W_WORDS + D_WORDS + S_WORDS;

  localparam logic [15:0] REDUCED_MASK = 16'hFFC0;
  localparam logic [15:0] RND_LOW_WORD = 16'h8000;
  localparam logic [31:0] RND_ADD = 32'h0000_8000;
  localparam int unsigned PROD_ALIGN = 1;
  localparam int unsigned ACC_HI_LSB = 16;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MAC_MOVE_TIME_NS = 80;
  localparam int unsigned MAC_MOVE_CYCLES = (MAC_MOVE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
    MAC_MOVE_TIME_NS / CLK_PERIOD_NS;

  localparam logic [1:0] SEL_WEIGHT = 2'h0;
  localparam logic [1:0] SEL_DELAY = 2'h1;
  localparam logic [1:0] SEL_SCRATCH = 2'h2;

  localparam logic [4:0] UE_SLOT = 5'h00;
  localparam logic [7:0] WEIGHT_BASE = 8'h00;
  localparam logic [8:0] NEWEST_SLOT = 9'h000;
  localparam logic [8:0] DPTR_ONE = 9'h001;
  localparam logic [7:0] FETCH_STEP = 8'h01;
  localparam logic [7:0] LOOP_ONE = 8'h01;
  localparam logic [7:0] LOOP_DONE = 8'h00;

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_FILTER   = 4'b0001,
    S_APAC     = 4'b0010,
    S_OUTPUT   = 4'b0011,
    S_UE_MPY   = 4'b0100,
    S_UE_ACC   = 4'b0101,
    S_UE_HOLD  = 4'b0110,
    S_U_MPY    = 4'b0111,
    S_U_LOAD   = 4'b1000,
    S_U_MAC_PREV = 4'b1001,
    S_U_LEAK   = 4'b1010,
    S_U_STORE  = 4'b1011
  } state_type;

  typedef enum logic [2:0] {
    OP_IDLE      = 3'b000,
    OP_CLEAR     = 3'b001,
    OP_CLR_MPY   = 3'b010,
    OP_MPY       = 3'b011,
    OP_ACC_MPY   = 3'b100,
    OP_ADD_P     = 3'b101,
    OP_LOAD_RND  = 3'b110,
    OP_SUB_SHIFT = 3'b111
  } mac_op_type;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] prod;
  } mac_state_type;

endpackage

// [design/mac_if.sv]
// control and result signals between the sequencer and the multiply-accumulate unit
interface mac_if import lms_pkg::*; ();
  mac_op_type op;
  logic [15:0] mcand;
  logic [15:0] operand;
  logic [15:0] load_word;
  logic [4:0] shift;
  logic [31:0] acc;

  modport ctrl (output op, output mcand, output operand, output load_word, output shift,
                input acc);
  modport unit (input op, input mcand, input operand, input load_word, input shift,
                output acc);
endinterface

// [design/mac_unit.sv]
// 16x16 multiplier, product register and 32-bit accumulator
module mac_unit import lms_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  mac_if.unit m
);

  mac_state_type s_r;
  mac_state_type s_nxt;
  logic signed [31:0] raw;
  logic [31:0] aligned;
  logic [31:0] leak;

  always_comb begin
    raw = $signed(m.mcand) * $signed(m.operand);
    // q15 times q15 gives q30; one left shift puts the product in q31
    aligned = raw << PROD_ALIGN;
    leak = {{16{m.load_word[15]}}, m.load_word} << m.shift;
    s_nxt = s_r;
    case (m.op)
      OP_CLEAR: s_nxt = '0;
      OP_CLR_MPY: begin
        s_nxt.acc = '0;
        s_nxt.prod = aligned;
      end
      OP_MPY: s_nxt.prod = aligned;
      OP_ACC_MPY: begin
        // full precision sum, no rounding between products
        s_nxt.acc = s_r.acc + s_r.prod;
        s_nxt.prod = aligned;
      end
      OP_ADD_P: s_nxt.acc = s_r.acc + s_r.prod;
      OP_LOAD_RND: s_nxt.acc = {m.load_word, RND_LOW_WORD};
      OP_SUB_SHIFT: s_nxt.acc = s_r.acc - leak;
      default: s_nxt = s_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign m.acc = s_r.acc;

  load_round_a: assert property (@(posedge clk) disable iff (rst)
    (m.op == OP_LOAD_RND) |=> (s_r.acc[15:0] == RND_LOW_WORD &&
                               s_r.acc[31:16] == $past(m.load_word)))
    else $error("load with round did not set low word to rounding pattern");

  acc_prev_a: assert property (@(posedge clk) disable iff (rst)
    (m.op == OP_ACC_MPY) |=> (s_r.acc == $past(s_r.acc) + $past(s_r.prod) &&
      s_r.prod == 32'($signed($past(m.mcand)) * $signed($past(m.operand))) << PROD_ALIGN))
    else $error("accumulate previous product went wrong");

  leak_sub_a: assert property (@(posedge clk) disable iff (rst)
    (m.op == OP_SUB_SHIFT) |=> (s_r.acc == $past(s_r.acc) -
      ({{16{$past(m.load_word[15])}}, $past(m.load_word)} << $past(m.shift))))
    else $error("leak term not subtracted");

endmodule

// [design/lms_adaptive_fir.sv]
// adaptive transversal fir with plain or leaky lms weight update
module lms_adaptive_fir import lms_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_IN,
  input wire logic [15:0] ERROR_IN,
  input wire logic [15:0] STEP_SIZE,
  input wire logic [7:0] TAP_COUNT_M1,
  input wire logic ADAPT_EN,
  input wire logic LEAKY_EN,
  input wire logic [4:0] LEAK_SHIFT,
  input wire logic REDUCED_PREC,
  input wire logic BLOCK0_PROGRAM,
  input wire logic MEM_WE,
  input wire logic [1:0] MEM_SEL,
  input wire logic [7:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  output logic [15:0] MEM_RDATA,
  output logic SAMPLE_READY,
  output logic OUT_VALID,
  output logic [15:0] OUT_SAMPLE,
  output logic BUSY,
  output logic CONFIG_ERR
);

  typedef struct packed {
    state_type st;
    logic [7:0] coefficient_fetch_pointer;
    logic [8:0] dptr;
    logic [7:0] loop;
    logic [15:0] t;
    logic ready;
    logic out_valid;
    logic [15:0] out_sample;
    logic busy;
    logic cfg_err;
    logic [15:0] mem_rdata;
  } ctl_state_type;

  ctl_state_type r;
  ctl_state_type n;

  // three local blocks, 544 words in total
  logic [15:0] weight_mem [W_WORDS];
  logic [15:0] delay_mem [D_WORDS];
  logic [15:0] scratch_mem [S_WORDS];

  logic w_we;
  logic [7:0] w_addr;
  logic [15:0] w_data;
  logic d_we;
  logic [8:0] d_addr;
  logic [15:0] d_data;
  logic s_we;
  logic [4:0] s_addr;
  logic [15:0] s_data;

  mac_if mbus ();

  mac_unit u_mac (
    .clk(CORE_CLK),
    .rst(RESET),
    .m(mbus.unit)
  );

  function automatic logic [15:0] round_hi(input logic [31:0] a);
    logic [31:0] s;
    s = a + RND_ADD;
    return s[31:ACC_HI_LSB];
  endfunction

  // slots past the end of the delay block read as zero, so the first
  // multiply of the update loop, at slot N, reads zero when N is 256
  function automatic logic [15:0] read_sample(input logic [8:0] addr, input logic reduced);
    logic [15:0] v;
    v = (32'(addr) < D_WORDS) ? delay_mem[addr[7:0]] : 16'h0000;
    return reduced ? (v & REDUCED_MASK) : v;
  endfunction

  always_comb begin
    n = r;
    mbus.op = OP_IDLE;
    mbus.mcand = '0;
    mbus.operand = '0;
    mbus.load_word = '0;
    mbus.shift = '0;
    w_we = 1'b0;
    w_addr = MEM_ADDR;
    w_data = MEM_WDATA;
    d_we = 1'b0;
    d_addr = {1'b0, MEM_ADDR};
    d_data = MEM_WDATA;
    s_we = 1'b0;
    s_addr = MEM_ADDR[4:0];
    s_data = MEM_WDATA;
    n.out_valid = 1'b0;
    n.cfg_err = BLOCK0_PROGRAM;
    case (MEM_SEL)
      SEL_WEIGHT: n.mem_rdata = weight_mem[MEM_ADDR];
      SEL_DELAY: n.mem_rdata = delay_mem[MEM_ADDR];
      SEL_SCRATCH: n.mem_rdata = scratch_mem[MEM_ADDR[4:0]];
      default: n.mem_rdata = 16'h0000;
    endcase
    case (r.st)
      S_IDLE: begin
        if (SAMPLE_VALID && r.ready) begin
          // a sample strobe starts exactly one filter pass
          d_we = 1'b1;
          d_addr = NEWEST_SLOT;
          d_data = SAMPLE_IN;
          mbus.op = OP_CLEAR;
          n.coefficient_fetch_pointer = WEIGHT_BASE;
          n.dptr = {1'b0, TAP_COUNT_M1};
          n.loop = TAP_COUNT_M1;
          n.st = S_FILTER;
        end else if (MEM_WE) begin
          // host writes only while idle; a sample strobe takes the port first
          w_we = (MEM_SEL == SEL_WEIGHT);
          d_we = (MEM_SEL == SEL_DELAY);
          s_we = (MEM_SEL == SEL_SCRATCH);
        end
      end
      S_FILTER: begin
        // one tap per clock, well inside the instruction time
        mbus.op = OP_ACC_MPY;
        mbus.mcand = weight_mem[r.coefficient_fetch_pointer];
        mbus.operand = read_sample(r.dptr, REDUCED_PREC);
        d_we = 1'b1;
        d_addr = r.dptr + DPTR_ONE;
        d_data = delay_mem[r.dptr[7:0]];
        n.coefficient_fetch_pointer = r.coefficient_fetch_pointer + FETCH_STEP;
        n.dptr = r.dptr - DPTR_ONE;
        if (r.loop == LOOP_DONE) begin
          n.st = S_APAC;
        end else begin
          n.loop = r.loop - LOOP_ONE;
        end
      end
      S_APAC: begin
        mbus.op = OP_ADD_P;
        n.st = S_OUTPUT;
      end
      S_OUTPUT: begin
        n.out_sample = round_hi(mbus.acc);
        n.out_valid = 1'b1;
        n.st = ADAPT_EN ? S_UE_MPY : S_IDLE;
      end
      S_UE_MPY: begin
        mbus.op = OP_CLR_MPY;
        mbus.mcand = STEP_SIZE;
        mbus.operand = ERROR_IN;
        n.st = S_UE_ACC;
      end
      S_UE_ACC: begin
        mbus.op = OP_ADD_P;
        n.st = S_UE_HOLD;
      end
      S_UE_HOLD: begin
        // step times error computed once and parked in the multiplicand
        n.t = round_hi(mbus.acc);
        s_we = 1'b1;
        s_addr = UE_SLOT;
        s_data = round_hi(mbus.acc);
        n.coefficient_fetch_pointer = WEIGHT_BASE;
        n.dptr = {1'b0, TAP_COUNT_M1} + DPTR_ONE;
        n.loop = TAP_COUNT_M1;
        n.st = S_U_MPY;
      end
      S_U_MPY: begin
        mbus.op = OP_MPY;
        mbus.mcand = r.t;
        mbus.operand = read_sample(r.dptr, REDUCED_PREC);
        n.dptr = r.dptr - DPTR_ONE;
        n.st = S_U_LOAD;
      end
      S_U_LOAD: begin
        mbus.op = OP_LOAD_RND;
        mbus.load_word = weight_mem[r.coefficient_fetch_pointer];
        n.st = S_U_MAC_PREV;
      end
      S_U_MAC_PREV: begin
        mbus.op = OP_ACC_MPY;
        mbus.mcand = r.t;
        mbus.operand = read_sample(r.dptr, REDUCED_PREC);
        n.dptr = r.dptr - DPTR_ONE;
        n.st = LEAKY_EN ? S_U_LEAK : S_U_STORE;
      end
      S_U_LEAK: begin
        mbus.op = OP_SUB_SHIFT;
        mbus.load_word = weight_mem[r.coefficient_fetch_pointer];
        mbus.shift = LEAK_SHIFT;
        n.st = S_U_STORE;
      end
      S_U_STORE: begin
        w_we = 1'b1;
        w_addr = r.coefficient_fetch_pointer;
        w_data = mbus.acc[31:ACC_HI_LSB];
        n.coefficient_fetch_pointer = r.coefficient_fetch_pointer + FETCH_STEP;
        if (r.loop == LOOP_DONE) begin
          n.st = S_IDLE;
        end else begin
          n.loop = r.loop - LOOP_ONE;
          n.st = S_U_LOAD;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // program mode on the weight block keeps the filter parked
    n.ready = (n.st == S_IDLE) && !BLOCK0_PROGRAM;
    n.busy = (n.st != S_IDLE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // the move into slot N is dropped when N is 256; keep N at 255 or less
  always_ff @(posedge CORE_CLK) begin
    if (w_we) begin
      weight_mem[w_addr] <= w_data;
    end
    if (d_we && 32'(d_addr) < D_WORDS) begin
      delay_mem[d_addr[7:0]] <= d_data;
    end
    if (s_we) begin
      scratch_mem[s_addr] <= s_data;
    end
  end

  assign MEM_RDATA = r.mem_rdata;
  assign SAMPLE_READY = r.ready;
  assign OUT_VALID = r.out_valid;
  assign OUT_SAMPLE = r.out_sample;
  assign BUSY = r.busy;
  assign CONFIG_ERR = r.cfg_err;

  fetch_step_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_FILTER) |=>
      (r.coefficient_fetch_pointer == $past(r.coefficient_fetch_pointer) + FETCH_STEP))
    else $error("coefficient pointer did not advance by one");

  delay_move_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_FILTER && r.dptr < 9'(D_WORDS - 1)) |=>
      (delay_mem[8'($past(r.dptr) + DPTR_ONE)] == $past(delay_mem[r.dptr[7:0]])))
    else $error("delay line sample not moved up");

  sample_mask_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (REDUCED_PREC && (r.st == S_FILTER || r.st == S_U_MAC_PREV)) |->
      ((mbus.operand & ~REDUCED_MASK) == 16'h0000))
    else $error("reduced precision sample not masked");

  out_round_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_OUTPUT) |=> (OUT_VALID && OUT_SAMPLE == round_hi($past(mbus.acc))))
    else $error("output not rounded from accumulator");

  one_pass_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (SAMPLE_VALID && SAMPLE_READY) |=> (!SAMPLE_READY && BUSY) [*3])
    else $error("sample accepted while a pass was running");

  loop_end_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_U_STORE && r.loop == LOOP_DONE) |=>
      (r.st == S_IDLE && (SAMPLE_READY || $past(BLOCK0_PROGRAM))))
    else $error("update loop did not end at counter expiry");

  store_upper_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_U_STORE) |=>
      (weight_mem[$past(r.coefficient_fetch_pointer)] == $past(mbus.acc[31:ACC_HI_LSB])))
    else $error("weight not written from accumulator upper word");

  ue_hold_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_U_LOAD) |-> (r.t == scratch_mem[UE_SLOT]))
    else $error("held step error term drifted");

  config_park_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (BLOCK0_PROGRAM) |=> (!SAMPLE_READY && CONFIG_ERR))
    else $error("filter ready while weight block is program storage");

  filter_len_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (r.st == S_IDLE && SAMPLE_VALID && r.ready) |=>
      (r.st == S_FILTER && r.loop == $past(TAP_COUNT_M1)))
    else $error("filter pass not started over all taps");

endmodule

// [verification/conv_model.sv]
// converter-side model: sample source toward the filter and output sink behind it
module conv_model (
  input wire logic clk,
  input wire logic ready,
  input wire logic out_valid,
  input wire logic [15:0] out_sample,
  output logic sample_valid,
  output logic [15:0] sample_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] dac_q[$];
  initial begin
    sample_valid = 1'b0;
    sample_in = 16'h0000;
  end
  // strobe and word stand until the edge that finds ready high
  task automatic send(input logic [15:0] x, input int gap, output bit ok);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge clk);
    #1;
    sample_valid = 1'b1;
    sample_in = x;
    while (ready !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
    // released word is inverted so a stale read cannot pass
    sample_in = ~x;
    ok = (n < 3000);
  endtask
  // one converter word collected per output pulse
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      dac_q.push_back(out_sample);
    end
  end
endmodule

// [verification/tb.sv]
// self-checking bench for the adaptive fir: reference model, stimulus and verdict
module tb import lms_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic svalid;
  wire logic [15:0] sdata;
  logic [15:0] err_in = 16'h0000;
  logic [15:0] step = 16'h0000;
  logic [7:0] nm1 = 8'h00;
  logic adapt = 1'b0;
  logic leaky = 1'b0;
  logic [4:0] lshift = 5'h00;
  logic reduced = 1'b0;
  logic prog = 1'b0;
  logic we = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, osample;
  logic ready, ovalid, busy, cfg_err;
  logic [15:0] wt [256];
  logic [15:0] dl [257];
  logic [15:0] term;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'he878;
  int errors = 0;
  int tests_run = 0;
  int t_nm1 [5] = '{0, 3, 4, 2, 7};
  bit t_ad [5] = '{0, 1, 1, 1, 0};
  bit t_lk [5] = '{0, 0, 1, 1, 0};
  int t_sh [5] = '{0, 0, 12, 14, 0};
  bit t_rp [5] = '{0, 0, 0, 1, 1};

  lms_adaptive_fir u_lms_adaptive_fir (
    .CORE_CLK(clk), .RESET(rst), .SAMPLE_VALID(svalid), .SAMPLE_IN(sdata),
    .ERROR_IN(err_in), .STEP_SIZE(step), .TAP_COUNT_M1(nm1), .ADAPT_EN(adapt),
    .LEAKY_EN(leaky), .LEAK_SHIFT(lshift), .REDUCED_PREC(reduced), .BLOCK0_PROGRAM(prog),
    .MEM_WE(we), .MEM_SEL(sel), .MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_RDATA(rdata),
    .SAMPLE_READY(ready), .OUT_VALID(ovalid), .OUT_SAMPLE(osample), .BUSY(busy),
    .CONFIG_ERR(cfg_err)
  );
  conv_model u_conv_model (
    .clk(clk), .ready(ready), .out_valid(ovalid), .out_sample(osample),
    .sample_valid(svalid), .sample_in(sdata)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic signed [15:0] msk(input logic [15:0] x);
    return reduced ? (x & REDUCED_MASK) : x;
  endfunction

  // reference pass: newest at slot 0, weight j pairs with slot n-1-j, then copy up
  task automatic model(input logic [15:0] x);
    int n;
    logic signed [31:0] a;
    logic signed [31:0] p;
    n = nm1 + 1;
    dl[0] = x;
    a = 32'sh0000_0000;
    for (int j = 0; j < n; j++) begin
      p = $signed(wt[j]) * msk(dl[n - 1 - j]);
      a = a + (p <<< 1);
    end
    for (int k = n - 1; k >= 0; k--) begin
      dl[k + 1] = dl[k];
    end
    a = a + RND_ADD;
    exp_q.push_back(a[31:16]);
    if (adapt) begin
      p = $signed(step) * $signed(err_in);
      p = (p <<< 1) + RND_ADD;
      term = p[31:16];
      for (int j = 0; j < n; j++) begin
        a = {wt[j], RND_LOW_WORD};
        p = $signed(term) * msk(dl[n - j]);
        a = a + (p <<< 1);
        if (leaky) begin
          a = a - ({{16{wt[j][15]}}, wt[j]} << lshift);
        end
        wt[j] = a[31:16];
      end
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    $display("Error %s expected done seen stalled", what);
    errors++;
    give_verdict();
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", what, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    we = 1'b1;
    sel = s;
    addr = a;
    wdata = d;
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    we = 1'b0;
    sel = s;
    addr = a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask
  task automatic idle();
    @(posedge clk);
    #1;
    we = 1'b0;
  endtask
  task automatic take(input int gap);
    bit ok;
    logic [15:0] x;
    x = rnd();
    model(x);
    u_conv_model.send(x, gap, ok);
    if (!ok) begin
      hang("sample take");
    end
  endtask
  // waits for the given output count and for the block to accept again
  task automatic settle(input int outs, output int n);
    n = 0;
    while ((u_conv_model.dac_q.size() < outs || ready !== 1'b1) && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      hang("pass end");
    end
  endtask

  initial begin
    logic [15:0] v;
    int n;
    int nt;
    repeat (3) @(posedge clk);
    #1;
    chk("ready in reset", 16'h0000, 16'(ready));
    chk("output in reset", 16'h0000, osample);
    rst = 1'b0;
    settle(0, n);
    wr(SEL_DELAY, 8'hff, 16'h5a5a);
    wr(SEL_SCRATCH, 8'h1f, 16'hc3c3);
    wr(SEL_WEIGHT, 8'hff, 16'h0f0f);
    rd(SEL_DELAY, 8'hff, v);
    chk("delay block top", 16'h5a5a, v);
    rd(SEL_SCRATCH, 8'h1f, v);
    chk("scratch block top", 16'hc3c3, v);
    rd(SEL_WEIGHT, 8'hff, v);
    chk("weight block top", 16'h0f0f, v);
    rd(2'h3, 8'h05, v);
    chk("unmapped block", 16'h0000, v);
    prog = 1'b1;
    repeat (2) idle();
    chk("ready as program store", 16'h0000, 16'(ready));
    chk("program store flag", 16'h0001, 16'(cfg_err));
    prog = 1'b0;
    settle(0, n);
    for (int c = 0; c < 5; c++) begin
      nm1 = t_nm1[c][7:0];
      adapt = t_ad[c];
      leaky = t_lk[c];
      lshift = t_sh[c][4:0];
      reduced = t_rp[c];
      err_in = rnd();
      step = rnd() >> 4;
      nt = nm1 + 1;
      for (int j = 0; j < nt; j++) begin
        wt[j] = rnd();
        wr(SEL_WEIGHT, j[7:0], wt[j]);
      end
      for (int k = 0; k <= nt; k++) begin
        dl[k] = 16'h0000;
        wr(SEL_DELAY, k[7:0], 16'h0000);
      end
      idle();
      take(c);
      n = 0;
      while (u_conv_model.dac_q.size() < 1 && n < 300) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 300) begin
        hang("first output");
      end
      if (!adapt) begin
        chk("output latency", 16'h0001, 16'(n == nt + 3));
        chk("ready after output", 16'h0001, 16'(ready));
      end else begin
        chk("busy in update", 16'h0001, 16'(busy));
        // host write during the pass must be dropped
        wr(SEL_WEIGHT, 8'h00, ~wt[0]);
        idle();
      end
      take(0);
      take(0);
      settle(3, n);
      repeat (4) idle();
      chk("outputs per sample", 16'h0003, 16'(u_conv_model.dac_q.size()));
      for (int i = 0; i < 3; i++) begin
        chk("filter output", exp_q.pop_front(), u_conv_model.dac_q.pop_front());
      end
      for (int j = 0; j < nt; j++) begin
        rd(SEL_WEIGHT, j[7:0], v);
        chk("weight", wt[j], v);
      end
      for (int k = 0; k <= nt; k++) begin
        rd(SEL_DELAY, k[7:0], v);
        chk("delay slot", dl[k], v);
      end
      if (adapt) begin
        rd(SEL_SCRATCH, {3'h0, UE_SLOT}, v);
        chk("scaled error", term, v);
      end
    end
    give_verdict();
  end
endmodule
